// ### smsp_peer.sv
// Purpose: far side of the serial link, slave or master, mode 0
// Assumes: msb first on the wire; select is owned here
// Notes:   a released line shows the inverse of its last bit
`timescale 1ns/10ps
`default_nettype none
module smsp_peer (
	// clock and wire levels
	input  wire logic pclk,
	input  wire logic sck_w,
	input  wire logic mosi_w,
	input  wire logic miso_w,
	input  wire logic ss_w,
	// what the peer drives
	output logic      p_sck,
	output logic      p_mosi,
	output logic      p_miso,
	output logic      p_ss
);
	logic [7:0] tx; // byte returned as slave
	logic [7:0] rx; // last byte seen on mosi
	logic [2:0] m = 3'h0; // falling edges since select went low; bits already shifted out on miso
	initial begin
		tx = 8'h3c;
		p_sck = 1'b0;
		p_mosi = 1'b0;
		p_ss = 1'b1;
	end
	// slave side samples mosi on the rising clock
	always @(posedge sck_w) if (!ss_w) rx <= {rx[6:0], mosi_w};
	// next bit set up on the falling clock; select high restarts
	always @(negedge sck_w or posedge ss_w) begin
		if (ss_w) m <= 3'h0;
		else m <= m + 3'h1;
	end
	assign p_miso = ss_w ? ~tx[0] : tx[~m];
	// select is lowered to open a packet, raised to close it
	task automatic sel(input logic v);
		@(posedge pclk);
		p_ss <= v;
	endtask : sel
	// master role; hold keeps select high to show idle pulses
	task automatic xfer(input logic [7:0] d, input int nb, input bit hold, output logic [7:0] q);
		q = 8'h00;
		for (int b = 0; b < nb; b++) begin
			@(posedge pclk);
			p_ss <= hold;
			p_mosi <= d[7-b];
			repeat (4) @(posedge pclk);
			p_sck <= 1'b1;
			@(negedge pclk);
			q[7-b] = miso_w;
			repeat (4) @(posedge pclk);
			p_sck <= 1'b0;
		end
		repeat (4) @(posedge pclk);
		p_ss <= 1'b1;
		p_mosi <= ~p_mosi;
	endtask : xfer
endmodule : smsp_peer
`default_nettype wire

// ### smsp_pkg.sv
// Purpose: constants and types for the serial master/slave port
// Assumes: apb register bus, 32-bit data, one word per register
// Notes:   all offsets are byte addresses
package smsp_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] DATA_OFFSET   = 8'h08;
	localparam logic [7:0] POWER_OFFSET  = 8'h0c;
	// control field positions
	localparam int CTRL_IRQ_EN_BIT  = 7;
	localparam int CTRL_ENABLE_BIT  = 6;
	localparam int CTRL_LSB_BIT     = 5;
	localparam int CTRL_MASTER_BIT  = 4;
	localparam int CTRL_CPOL_BIT    = 3;
	localparam int CTRL_CPHA_BIT    = 2;
	localparam int CTRL_RATE_HI_BIT = 1;
	localparam int CTRL_RATE_LO_BIT = 0;
	localparam int CTRL_SS_OUT_BIT  = 8;
	// status field positions
	localparam int STAT_DONE_BIT  = 7;
	localparam int STAT_WCOL_BIT  = 6;
	localparam int STAT_DOUBLE_BIT = 0;
	// reset values
	localparam logic [8:0] CTRL_RESET  = 9'h000;
	localparam logic       POWER_RESET = 1'b1;
	// slave clock filter: edge needs this many equal samples
	localparam logic [1:0] SCK_STABLE_CYCLES = 2'h2;
	// master state machine
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT} smsp_state_type;
endpackage : smsp_pkg

// ### smsp_port.sv
// Purpose: byte-wide full-duplex serial port, master or slave, apb registers
// Assumes: pins synchronous to pclk; pad logic combines enables
// Notes:   reading data register does not clear the done flag; write 1 clears
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module smsp_port (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// serial clock pin
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	// controller out pin
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe,
	// controller in pin
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe,
	// select pin (active low)
	input  wire logic        ss_n_in,
	output logic             ss_n_out,
	output logic             ss_n_oe,
	// interrupt request
	output logic             irq
);
	// registers
	logic [8:0] ctrl_q, ctrl_d;           // control incl. select-output bit, which only masks the mode fault
	logic       power_cut_q, power_cut_d; // serial_port_power_cut
	logic       double_q, double_d;       // rate_double
	logic       done_q, done_d;           // transfer_done_flag
	logic       wcol_q, wcol_d;           // write collision
	logic [7:0] shift_q, shift_d;         // shift register
	logic [7:0] rxbuf_q, rxbuf_d;         // receive buffer
	logic [2:0] bits_q, bits_d;           // bits sampled so far
	logic [6:0] div_q, div_d;             // master rate divider
	logic       sclk_q, sclk_d;           // master clock level
	logic       half_q, half_d;           // 0: leading edge next
	logic       sck_f_q, sck_f_d;         // filtered slave clock
	logic [1:0] sck_cnt_q, sck_cnt_d;     // filter agreement count
	logic       lat_q, lat_d;             // sampled bit waiting to be shifted
	logic       out_q, out_d;             // serial output bit
	smsp_pkg::smsp_state_type st_q, st_d;

	// control decode
	logic active, master, lsb, cpol, cpha, irq_en, ss_is_out, selected;
	logic [6:0] div_last;
	logic wr, tick, s_lead, s_trail, s_edge, samp, setup, done_ev, mode_fault;
	logic [7:0] shifted;

	assign active    = ctrl_q[smsp_pkg::CTRL_ENABLE_BIT] & ~power_cut_q;
	assign master    = ctrl_q[smsp_pkg::CTRL_MASTER_BIT];
	assign lsb       = ctrl_q[smsp_pkg::CTRL_LSB_BIT];
	assign cpol      = ctrl_q[smsp_pkg::CTRL_CPOL_BIT];
	assign cpha      = ctrl_q[smsp_pkg::CTRL_CPHA_BIT];
	assign irq_en    = ctrl_q[smsp_pkg::CTRL_IRQ_EN_BIT];
	assign ss_is_out = ctrl_q[smsp_pkg::CTRL_SS_OUT_BIT];
	assign selected  = ~ss_n_in;
	// another master pulls our input select low while we are master
	assign mode_fault = active & master & ~ss_is_out & ~ss_n_in;

	// half-period minus one for each rate; the divider toggles sck
	function automatic logic [6:0] rate_last(input logic dbl, input logic [1:0] sel);
		logic [6:0] r;
		r = 7'h00;
		case ({dbl, sel})
			3'b000:  r = 7'h01; // /4
			3'b001:  r = 7'h07; // /16
			3'b010:  r = 7'h1f; // /64
			3'b011:  r = 7'h3f; // /128
			3'b100:  r = 7'h00; // /2
			3'b101:  r = 7'h03; // /8
			3'b110:  r = 7'h0f; // /32
			default: r = 7'h1f; // /64 again
		endcase
		return r;
	endfunction : rate_last

	assign div_last = rate_last(double_q, ctrl_q[1:0]);

	// apb: zero wait states, error on unmapped address
	assign wr      = psel & penable & pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (paddr != smsp_pkg::CTRL_OFFSET) &
		(paddr != smsp_pkg::STATUS_OFFSET) & (paddr != smsp_pkg::DATA_OFFSET) &
		(paddr != smsp_pkg::POWER_OFFSET);

	// read mux
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			smsp_pkg::CTRL_OFFSET:   prdata = {23'h000000, ctrl_q};
			smsp_pkg::STATUS_OFFSET: prdata = {24'h000000, done_q, wcol_q, 5'h00, double_q};
			smsp_pkg::DATA_OFFSET:   prdata = {24'h000000, rxbuf_q};
			smsp_pkg::POWER_OFFSET:  prdata = {31'h00000000, power_cut_q};
			default:                 prdata = 32'h0000_0000;
		endcase
	end

	// edge decode: master from divider, slave from filtered pin
	assign tick    = (st_q == smsp_pkg::ST_SHIFT) & (div_q == div_last);
	assign shifted = lsb ? {lat_q, shift_q[7:1]} : {shift_q[6:0], lat_q};

	// next-state logic for the whole port
	always_comb begin
		ctrl_d      = ctrl_q;
		power_cut_d = power_cut_q;
		double_d    = double_q;
		done_d      = done_q;
		wcol_d      = wcol_q;
		shift_d     = shift_q;
		rxbuf_d     = rxbuf_q;
		bits_d      = bits_q;
		div_d       = div_q;
		sclk_d      = sclk_q;
		half_d      = half_q;
		lat_d       = lat_q;
		out_d       = out_q;
		st_d        = st_q;
		sck_f_d     = sck_f_q;
		sck_cnt_d   = sck_cnt_q;
		s_lead      = 1'b0;
		s_trail     = 1'b0;
		done_ev     = 1'b0;
		// slave clock filter: new level must persist; the filter simply follows
		// the pin while inactive or unselected, so a stale level after reset or a
		// polarity change never turns into a false edge
		if (!active || !selected || sck_in == sck_f_q) begin
			sck_f_d   = sck_in;
			sck_cnt_d = 2'h0;
		end else if (sck_cnt_q == smsp_pkg::SCK_STABLE_CYCLES - 2'h1) begin
			sck_f_d   = sck_in;
			sck_cnt_d = 2'h0;
			s_lead    = (sck_in != cpol);
			s_trail   = (sck_in == cpol);
		end else begin
			sck_cnt_d = sck_cnt_q + 2'h1;
		end
		// master clock generator
		if (tick) begin
			div_d  = 7'h00;
			sclk_d = ~sclk_q;
			half_d = ~half_q;
		end else if (st_q == smsp_pkg::ST_SHIFT) begin
			div_d = div_q + 7'h01;
		end
		s_edge = master ? tick : (selected & (s_lead | s_trail));
		// leading edge when half is 0; sample on leading iff cpha=0
		samp  = s_edge & ((master ? ~half_q : s_lead) ^ cpha);
		setup = s_edge & ~((master ? ~half_q : s_lead) ^ cpha);
		if (samp) begin
			lat_d = master ? miso_in : mosi_in;
		end
		// shift in the bit caught last edge, present next bit; with no bit
		// caught yet (first cpha=1 leading edge, or the edge after the last
		// sample) the loaded or received byte must stay put
		if (setup && bits_q != 3'h0) begin
			shift_d = shifted;
			out_d   = lsb ? shifted[0] : shifted[7];
		end
		if (samp) begin
			bits_d = bits_q + 3'h1;
			if (bits_q == 3'h7) begin
				done_ev = 1'b1; // eight bits sampled
			end
		end
		// byte completion: last bit goes straight into the buffer
		if (done_ev) begin
			rxbuf_d = lsb ? {lat_d, shift_q[7:1]} : {shift_q[6:0], lat_d};
			shift_d = rxbuf_d;
			bits_d  = 3'h0;
			done_d  = 1'b1;
			if (!master) begin
				// slave presents the first bit of its byte before the next leading edge
				out_d = lsb ? rxbuf_d[0] : rxbuf_d[7];
			end
		end
		// master stops on the first trailing edge at or after the eighth sample, so all
		// sixteen edges reach the pin and sck rests at its idle level
		if (master && tick && half_q && (done_ev || (!cpha && bits_q == 3'h0))) begin
			st_d   = smsp_pkg::ST_IDLE;
			sclk_d = cpol;
			half_d = 1'b0;
			div_d  = 7'h00;
		end
		// slave deselect drops partial bits
		if (!master && !selected) begin
			bits_d = 3'h0;
			lat_d  = 1'b0;
			out_d  = lsb ? shift_q[0] : shift_q[7];
		end
		// select low on input select while master: become slave
		if (mode_fault) begin
			ctrl_d[smsp_pkg::CTRL_MASTER_BIT] = 1'b0;
			done_d = 1'b1;
			st_d   = smsp_pkg::ST_IDLE;
			sclk_d = cpol;
			half_d = 1'b0;
			bits_d = 3'h0;
		end
		// register writes; hardware sets win over software clears
		if (wr) begin
			case (paddr)
				smsp_pkg::CTRL_OFFSET: begin
					ctrl_d = pwdata[8:0];
					if (st_q == smsp_pkg::ST_IDLE) begin
						sclk_d = pwdata[smsp_pkg::CTRL_CPOL_BIT];
					end
				end
				smsp_pkg::STATUS_OFFSET: begin
					double_d = pwdata[smsp_pkg::STAT_DOUBLE_BIT];
					if (pwdata[smsp_pkg::STAT_DONE_BIT] && !done_ev && !mode_fault) begin
						done_d = 1'b0;
					end
					if (pwdata[smsp_pkg::STAT_WCOL_BIT]) begin
						wcol_d = 1'b0;
					end
				end
				smsp_pkg::DATA_OFFSET: begin
					if (st_q == smsp_pkg::ST_SHIFT || (!master && selected && bits_q != 3'h0)) begin
						wcol_d = 1'b1;
					end else begin
						shift_d = pwdata[7:0];
						out_d   = lsb ? pwdata[0] : pwdata[7];
						if (master && active) begin
							st_d   = smsp_pkg::ST_SHIFT;
							div_d  = 7'h00;
							half_d = 1'b0;
							sclk_d = cpol;
							bits_d = 3'h0;
						end
					end
				end
				smsp_pkg::POWER_OFFSET: power_cut_d = pwdata[0];
				default: ;
			endcase
		end
		// inactive port holds shift machinery still
		if (!active) begin
			st_d   = smsp_pkg::ST_IDLE;
			bits_d = 3'h0;
			div_d  = 7'h00;
			half_d = 1'b0;
		end
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q      <= smsp_pkg::CTRL_RESET;
			power_cut_q <= smsp_pkg::POWER_RESET;
			double_q    <= 1'b0;
			done_q      <= 1'b0;
			wcol_q      <= 1'b0;
			shift_q     <= 8'h00;
			rxbuf_q     <= 8'h00;
			bits_q      <= 3'h0;
			div_q       <= 7'h00;
			sclk_q      <= 1'b0;
			half_q      <= 1'b0;
			sck_f_q     <= 1'b0;
			sck_cnt_q   <= 2'h0;
			lat_q       <= 1'b0;
			out_q       <= 1'b0;
			st_q        <= smsp_pkg::ST_IDLE;
		end else begin
			ctrl_q      <= ctrl_d;
			power_cut_q <= power_cut_d;
			double_q    <= double_d;
			done_q      <= done_d;
			wcol_q      <= wcol_d;
			shift_q     <= shift_d;
			rxbuf_q     <= rxbuf_d;
			bits_q      <= bits_d;
			div_q       <= div_d;
			sclk_q      <= sclk_d;
			half_q      <= half_d;
			sck_f_q     <= sck_f_d;
			sck_cnt_q   <= sck_cnt_d;
			lat_q       <= lat_d;
			out_q       <= out_d;
			st_q        <= st_d;
		end
	end

	// pin overrides; select is never driven, ss_n_oe is tied low
	assign sck_out  = sclk_q;
	assign sck_oe   = active & master;
	assign mosi_out = out_q;
	assign mosi_oe  = active & master;
	assign miso_out = out_q;
	assign miso_oe  = active & ~master & selected;
	assign ss_n_out = 1'b1;
	assign ss_n_oe  = 1'b0;
	assign irq      = done_q & irq_en & ~power_cut_q;
endmodule : smsp_port
`default_nettype wire

// ### smsp_port_asserts.sv
// Purpose: concurrent checks on the serial port pins
// Assumes: one pclk domain, async active-low reset
// Notes:   sees top-level ports only, attached by bind
`timescale 1ns/10ps
`default_nettype none
module smsp_port_chk (
	// clock, reset and apb request
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// pins and interrupt
	input wire logic        sck_out,
	input wire logic        sck_oe,
	input wire logic        mosi_oe,
	input wire logic        miso_oe,
	input wire logic        miso_out,
	input wire logic        ss_n_in,
	input wire logic        ss_n_oe,
	input wire logic        irq
);
	logic       pw_q;  // power cut as last written
	logic       en_q;  // irq enable as last written
	logic       sck_q; // sck one cycle ago
	logic [4:0] ec_q;  // sck edges since the last apb write, saturating
	wire        wr_go = psel && penable && pwrite;
	// shadow the control bits the pins depend on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pw_q  <= smsp_pkg::POWER_RESET;
			en_q  <= 1'b0;
			sck_q <= 1'b0;
			ec_q  <= 5'h00;
		end else begin
			sck_q <= sck_out;
			if (wr_go && paddr == smsp_pkg::POWER_OFFSET) pw_q <= pwdata[0];
			if (wr_go && paddr == smsp_pkg::CTRL_OFFSET) en_q <= pwdata[7];
			// any write restarts the count, so a collision cannot overcount
			if (wr_go) ec_q <= 5'h00;
			else if (sck_out != sck_q && ec_q != 5'h1f) ec_q <= ec_q + 5'h01;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SS_FREE: assert property (!ss_n_oe)
		else $error("select pin driven");
	AST_MISO_REL: assert property (ss_n_in [*2] |-> !miso_oe)
		else $error("miso driven while unselected");
	AST_ONE_ROLE: assert property (!(sck_oe && miso_oe))
		else $error("master and slave pins both driven");
	AST_MOSI_SCK: assert property (mosi_oe == sck_oe)
		else $error("mosi and sck directions differ");
	// one cycle of slack in case the enables are registered
	AST_POWER: assert property (pw_q && $past(pw_q) |-> !sck_oe && !miso_oe && !irq)
		else $error("port active while power cut");
	AST_EDGES: assert property (ec_q <= 5'h10)
		else $error("more than sixteen sck edges per write");
	AST_IRQ_MASK: assert property (!en_q && !$past(en_q) |-> !irq)
		else $error("irq while disabled");
	AST_SLV_HOLD: assert property ((ss_n_in && !psel && !sck_oe) [*4] |-> $stable(miso_out))
		else $error("slave shifted while unselected");
endmodule : smsp_port_chk
bind smsp_port smsp_port_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .sck_out, .sck_oe, .mosi_oe, .miso_oe, .miso_out, .ss_n_in, .ss_n_oe, .irq);
`default_nettype wire

// ### tb.sv
// Purpose: self-checking bench for the serial master/slave port
// Assumes: peer answers in mode 0; apb without wait states
// Notes:   rates checked by counting sck high cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0]  paddr, sb, bt;
	logic [31:0] pwdata, prdata, q;
	logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe;
	logic        p_sck, p_mosi, p_miso, p_ss;
	wire         sck_w, mosi_w, miso_w, ss_w;
	int          n_fail, checks, cyc, hc;
	int          dv[7] = '{4, 16, 64, 128, 2, 8, 32};
	// wire level: an enabled driver wins, else the peer
	assign sck_w = sck_oe ? sck_out : p_sck;
	assign mosi_w = mosi_oe ? mosi_out : p_mosi;
	assign miso_w = miso_oe ? miso_out : p_miso;
	assign ss_w = ss_n_oe ? ss_n_out : p_ss;
	smsp_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out,
		.mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe, .ss_n_in(ss_w), .ss_n_out,
		.ss_n_oe, .irq);
	smsp_peer peer (.pclk, .sck_w, .mosi_w, .miso_w, .ss_w, .p_sck, .p_mosi, .p_miso, .p_ss);
	always #25 pclk = ~pclk;
	// hang guard and sck high-time counter
	always @(posedge pclk) begin
		cyc++;
		if (sck_w === 1'b1) hc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic summarize();
		if (n_fail == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : cmp
	// one apb transfer; answer taken at the edge where pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic r;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait count assumed; data and error are taken with pready
		do begin
			@(posedge pclk);
			q = prdata;
			err = pslverr;
			r = pready;
		end while (r !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// send one byte as master; return only after done is set and sck is back low
	task automatic mx(input logic [7:0] d);
		apb(1'b1, smsp_pkg::DATA_OFFSET, {24'h0, d});
		do begin
			apb(1'b0, smsp_pkg::STATUS_OFFSET, 32'h0);
		end while (q[7] !== 1'b1);
		while (sck_w !== 1'b0) begin
			@(posedge pclk);
		end
		repeat (2) @(posedge pclk);
	endtask : mx
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{n_fail, checks, cyc, hc} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, smsp_pkg::CTRL_OFFSET, 32'h0);
		cmp(q, 32'h0);
		apb(1'b0, smsp_pkg::POWER_OFFSET, 32'h0);
		cmp(q, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		cmp({31'h0, err}, 32'h1);
		peer.sel(1'b0);
		apb(1'b1, smsp_pkg::CTRL_OFFSET, 32'h1d1);
		apb(1'b1, smsp_pkg::DATA_OFFSET, 32'ha5);
		repeat (40) @(posedge pclk);
		apb(1'b0, smsp_pkg::STATUS_OFFSET, 32'h0);
		cmp(q & 32'h80, 32'h0);
		apb(1'b1, smsp_pkg::POWER_OFFSET, 32'h0);
		// all seven rates; irq masked on the first pass only
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, smsp_pkg::STATUS_OFFSET, (i > 3) ? 32'hc1 : 32'hc0);
			apb(1'b1, smsp_pkg::CTRL_OFFSET, ((i > 0) ? 32'h1d0 : 32'h150) | 32'(i % 4));
			bt = 8'(i * 37 + 5);
			peer.tx = ~bt;
			hc = 0;
			mx(bt);
			cmp({24'h0, peer.rx}, {24'h0, bt});
			cmp(32'(hc), 32'(4 * dv[i]));
			cmp({31'h0, irq}, 32'(i > 0));
			apb(1'b0, smsp_pkg::DATA_OFFSET, 32'h0);
			cmp(q & 32'hff, {24'h0, ~bt});
		end
		apb(1'b1, smsp_pkg::STATUS_OFFSET, 32'hc0);
		cmp({31'h0, irq}, 32'h0);
		apb(1'b1, smsp_pkg::DATA_OFFSET, 32'h5a);
		apb(1'b1, smsp_pkg::DATA_OFFSET, 32'hff);
		mx(8'h5a);
		cmp(q & 32'hc0, 32'hc0);
		cmp({24'h0, peer.rx}, 32'h5a);
		apb(1'b1, smsp_pkg::STATUS_OFFSET, 32'hc0);
		apb(1'b1, smsp_pkg::CTRL_OFFSET, 32'h1f0);
		mx(8'h01);
		cmp({24'h0, peer.rx}, 32'h80);
		peer.sel(1'b1);
		apb(1'b1, smsp_pkg::STATUS_OFFSET, 32'hc0);
		apb(1'b1, smsp_pkg::CTRL_OFFSET, 32'h040);
		apb(1'b1, smsp_pkg::DATA_OFFSET, 32'h96);
		peer.xfer(8'h3c, 8, 1'b1, sb);
		apb(1'b0, smsp_pkg::STATUS_OFFSET, 32'h0);
		cmp(q & 32'h80, 32'h0);
		peer.xfer(8'h3c, 8, 1'b0, sb);
		cmp({24'h0, sb}, 32'h96);
		apb(1'b0, smsp_pkg::STATUS_OFFSET, 32'h0);
		cmp(q & 32'h80, 32'h80);
		apb(1'b0, smsp_pkg::DATA_OFFSET, 32'h0);
		cmp(q & 32'hff, 32'h3c);
		apb(1'b1, smsp_pkg::STATUS_OFFSET, 32'hc0);
		peer.xfer(8'hff, 3, 1'b0, sb);
		apb(1'b0, smsp_pkg::STATUS_OFFSET, 32'h0);
		cmp(q & 32'h80, 32'h0);
		peer.xfer(8'h42, 8, 1'b0, sb);
		apb(1'b0, smsp_pkg::DATA_OFFSET, 32'h0);
		cmp(q & 32'hff, 32'h42);
		apb(1'b1, smsp_pkg::STATUS_OFFSET, 32'hc0);
		apb(1'b1, smsp_pkg::CTRL_OFFSET, 32'h0d0);
		peer.sel(1'b0);
		repeat (4) @(posedge pclk);
		apb(1'b0, smsp_pkg::CTRL_OFFSET, 32'h0);
		cmp(q & 32'h10, 32'h0);
		apb(1'b0, smsp_pkg::STATUS_OFFSET, 32'h0);
		cmp(q & 32'h80, 32'h80);
		summarize();
	end
endmodule : tb
`default_nettype wire
